// file: bench/ext_reset_src.sv
// external reset source: holds the reset pin low for a loaded count
`default_nettype none
module ext_reset_src (
  input wire logic       i_clk,
  input wire logic       i_go,
  input wire logic [7:0] i_len,
  output logic           o_pin_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left = 8'h00;
  assign o_pin_n = (left == 8'h00);
  // loads on the rising edge so the falling-edge go from the bench never races it
  always @(posedge i_clk)
    if (i_go)
      left <= i_len;
    else if (left != 8'h00)
      left <= left - 8'h01;
endmodule
`default_nettype wire

// file: bench/rsc_chk_assertions.sv
// assertion checker for the reset and standby controller
`default_nettype none
module rsc_chk #(parameter int PORT_PINS = 8) (
  input wire logic i_clk, i_rst_n, i_stop_exec, i_cpu_on_main_crystal,
  input wire logic i_wdt_overflow, i_clock_monitor_trip, i_low_voltage_detect,
  input wire logic [31:0] i_irq_request, i_irq_mask,
  input wire logic [PORT_PINS-1:0] o_port_oe_n,
  input wire logic o_port13_bit0_oe_n, o_port13_bit0_low_output, o_main_crystal_clock_run,
  input wire logic o_internal_ring_clock_run, o_system_reset_n, o_wdt_reset_n,
  input wire logic o_low_voltage_detector_reset_n, o_cpu_clock_enable, o_halted,
  input wire logic o_stopped, o_clock_monitor_enable,
  input wire logic [7:0] o_reset_cause_flags
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire wake = |(i_irq_request & ~i_irq_mask);
  wire run  = o_cpu_clock_enable && !o_halted && !o_stopped;
  a_osc_halt: assert property (disable iff (1'b0)
    !i_rst_n |=> !o_main_crystal_clock_run && !o_internal_ring_clock_run) else $error("osc ran");
  a_port_float: assert property (!o_system_reset_n |-> &o_port_oe_n &&
    !o_port13_bit0_oe_n && !o_port13_bit0_low_output) else $error("port driven in reset");
  a_wake_stop: assert property (
    o_stopped && wake |-> ##[1:3] !o_stopped) else $error("stop kept despite wake");
  a_stop_pending: assert property (
    i_stop_exec && wake && run |-> ##2 o_halted && !o_stopped) else $error("no halt fall");
  a_wdt_self: assert property (
    i_wdt_overflow |=> !o_wdt_reset_n && !o_system_reset_n) else $error("wdt not reset");
  a_lvd_spare: assert property (i_low_voltage_detect |=> !o_system_reset_n &&
    o_low_voltage_detector_reset_n) else $error("detector reset");
  a_clm_flag: assert property (i_clock_monitor_trip |-> ##[1:2]
    o_reset_cause_flags == 8'h02 && !o_clock_monitor_enable) else $error("monitor flag");
  a_cause_keep: assert property (
    i_wdt_overflow && !i_clock_monitor_trip && !i_low_voltage_detect |=>
    o_reset_cause_flags == 8'h01 ##1 o_reset_cause_flags == 8'h01) else $error("wdt flag lost");
endmodule
bind reset_standby_control rsc_chk #(.PORT_PINS(PORT_PINS)) chk (.*);
`default_nettype wire

// file: bench/tb_top.sv
// testbench for the reset and standby controller
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, stop = 0, wdt = 0, clm = 0, lvd = 0, we = 0, cme_set = 0, go = 0;
  logic halt = 0;
  logic [31:0] req = 32'h0, msk = 32'h0;
  logic [7:0] len = 8'h00, pe, flags, po;
  logic [2:0] ssel, ssd = 3'h0;
  logic pin_n, p13e, xr, rr, srst, cen, halted, stopped, hold, cme;
  int error_cnt = 0, checks_done = 0, n;
  initial forever #2.5 clk = ~clk;
  ext_reset_src src (.i_clk(clk), .i_go(go), .i_len(len), .o_pin_n(pin_n));
  reset_standby_control #(.EXT_RESET_CYCLES(8)) uut (.i_clk(clk), .i_rst_n(rst_n),
    .i_ext_reset_pin_n(pin_n), .i_wdt_overflow(wdt), .i_clock_monitor_trip(clm),
    .i_low_voltage_detect(lvd), .i_stop_exec(stop), .i_halt_exec(halt),
    .i_cpu_on_main_crystal(1'b1), .i_irq_request(req), .i_irq_mask(msk),
    .i_settle_select_we(we), .i_settle_select_data(ssd), .i_clock_monitor_enable_set(cme_set),
    .i_port_out(8'h5a), .i_port_drive(8'hff), .o_port_out(po), .o_port_oe_n(pe),
    .o_port13_bit0_low_output(), .o_port13_bit0_oe_n(p13e), .o_main_crystal_clock_run(xr),
    .o_internal_ring_clock_run(rr), .o_system_reset_n(srst), .o_wdt_reset_n(),
    .o_low_voltage_detector_reset_n(), .o_cpu_clock_enable(cen), .o_halted(halted),
    .o_stopped(stopped), .o_stop_retain_hold(hold), .o_osc_settle_select(ssel),
    .o_clock_monitor_enable(cme), .o_reset_cause_flags(flags));
  task step(input int c);
    repeat (c) @(negedge clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // settle wait is 2^(11+select) cycles; only a bounded wait for run
  task settle(input int lo, input int hi);
    n = 0;
    while (!(cen === 1'b1 && halted === 1'b0) && n < 5000)
    begin
      step(1);
      n++;
    end
    chk("settle cycles", 1, lo <= n && n <= hi);
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    step(5);
    chk("reset ports", 10'h1ff, {p13e, flags == 8'h00, pe});
    chk("reset osc", 2'b00, {xr, rr});
    rst_n = 1'b1;
    step(2);
    pulse(we);
    step(2);
    chk("settle sel", 3'h0, ssel);
    chk("port run", 16'h5a00, {po, pe});
    $display("reset test done");
    pulse(stop);
    step(3);
    chk("stop osc", 2'b10, {stopped, xr});
    msk = 32'h20;
    req = 32'h20;
    step(4);
    chk("masked wake", 1'b1, stopped);
    msk = 32'h0;
    settle(2048, 2058);
    req = 32'h1;
    pulse(stop);
    step(2);
    chk("halt fall", 2'b10, {halted, stopped});
    settle(2040, 2058);
    pulse(halt);
    step(1);
    chk("halt refused", 2'b01, {halted, cen});
    req = 32'h0;
    pulse(halt);
    step(1);
    chk("halt entry", 2'b10, {halted, cen});
    ssd = 3'h1;
    pulse(we);
    step(1);
    chk("settle refused", 3'h0, ssel);
    req = 32'h80;
    step(2);
    chk("halt wake", 2'b01, {halted, cen});
    req = 32'h0;
    $display("standby test done");
    pulse(cme_set);
    step(1);
    chk("monitor en", 1'b1, cme);
    pulse(wdt);
    step(2);
    chk("wdt flags", 8'h01, flags);
    pulse(clm);
    step(2);
    chk("clm flags", 9'h002, {cme, flags});
    pulse(lvd);
    step(2);
    chk("lvd flags", 8'h04, flags);
    len = 8'h04;
    pulse(go);
    step(8);
    chk("short pin", 1'b1, srst);
    step(4);
    pulse(stop);
    step(3);
    len = 8'h20;
    pulse(go);
    step(16);
    chk("pin reset", 12'h8ff, {hold, srst, xr, rr, pe});
    step(30);
    chk("pin release", 1'b1, srst);
    $display("reset source test done");
    report_and_stop;
  end
  initial
  begin
    #100us;
    error_cnt++;
    report_and_stop;
  end
endmodule
`default_nettype wire

// file: rtl/reset_standby_control.v
// reset and standby controller: stop/halt sequencing, reset qualification, cause flags
// Behaviour
// - any requested and unmasked interrupt ends a standby state: halt at once, stop after the settle wait.
// - stop with a wake already pending falls to halt, then runs after the settle wait.
// - both the crystal and the ring oscillator are halted during power-on or external pin reset; internal resets leave them running.
// - retained stop contents are held unchanged while reset stays asserted.
// - during reset every port pin floats except one bit, which drives low.
// - a low-voltage reset resets the rest of the device but not the detector.
// - a watchdog overflow reset also resets the watchdog itself.
// - a power-on-clear reset clears all reset cause flags to zero.
// - a clock monitor reset clears the monitor enable and sets cause bit 1.
`include "reset_standby_map.vh"
`default_nettype none

module reset_standby_control #(
  parameter integer PORT_PINS        = 8,
  parameter integer EXT_RESET_CYCLES = `EXT_RESET_CYCLES
) (
  // clock and power-on reset
  input  wire                            i_clk,
  input  wire                            i_rst_n,
  // external reset pin, asynchronous
  input  wire                            i_ext_reset_pin_n,
  // internal reset requests, one-cycle pulses
  input  wire                            i_wdt_overflow,
  input  wire                            i_clock_monitor_trip,
  input  wire                            i_low_voltage_detect,
  // standby requests from the cpu, one-cycle pulses, and the cpu clock source level
  input  wire                            i_stop_exec,
  input  wire                            i_halt_exec,
  input  wire                            i_cpu_on_main_crystal,
  // interrupt request and mask flags
  input  wire [31:0]                     i_irq_request,
  input  wire [31:0]                     i_irq_mask,
  // firmware controls
  input  wire                            i_settle_select_we,
  input  wire [`SETTLE_SEL_WIDTH-1:0]    i_settle_select_data,
  input  wire                            i_clock_monitor_enable_set,
  // port pins, output enable low while driven
  input  wire [PORT_PINS-1:0]            i_port_out,
  input  wire [PORT_PINS-1:0]            i_port_drive,
  output reg  [PORT_PINS-1:0]            o_port_out,
  output reg  [PORT_PINS-1:0]            o_port_oe_n,
  output reg                             o_port13_bit0_low_output,
  output reg                             o_port13_bit0_oe_n,
  // oscillator and reset outputs
  output reg                             o_main_crystal_clock_run,
  output reg                             o_internal_ring_clock_run,
  output reg                             o_system_reset_n,
  output reg                             o_wdt_reset_n,
  output reg                             o_low_voltage_detector_reset_n,
  output reg                             o_cpu_clock_enable,
  output reg                             o_halted,
  output reg                             o_stopped,
  output reg                             o_stop_retain_hold,
  output reg  [`SETTLE_SEL_WIDTH-1:0]    o_osc_settle_select,
  output reg                             o_clock_monitor_enable,
  output reg  [`CAUSE_WIDTH-1:0]         o_reset_cause_flags
);

  // ****************************************
  // state codes
  // ****************************************
  localparam [3:0] ST_RUN    = 4'h1;
  localparam [3:0] ST_HALT   = 4'h2;
  localparam [3:0] ST_STOP   = 4'h4;
  localparam [3:0] ST_SETTLE = 4'h8;

  // ****************************************
  // external pin synchroniser and qualifier
  // ****************************************
  reg        pin_meta;
  reg        pin_sync;
  reg [15:0] low_count;
  reg        ext_reset;

  always @(posedge i_clk)
  begin
    pin_meta <= i_ext_reset_pin_n;
    pin_sync <= pin_meta;
  end

  // short glitches never reach the reset net
  always @(posedge i_clk)
  begin
    if (!i_rst_n || pin_sync)
    begin
      low_count <= 16'h0000;
      ext_reset <= 1'b0;
    end
    else if (low_count >= EXT_RESET_CYCLES[15:0] - 16'h0001)
      ext_reset <= 1'b1;
    else
      low_count <= low_count + 16'h0001;
  end

  wire wake    = |(i_irq_request & ~i_irq_mask);
  wire int_rst = i_wdt_overflow | i_clock_monitor_trip | i_low_voltage_detect;
  wire any_rst = !i_rst_n || ext_reset;

  // ****************************************
  // standby state machine and settle wait
  // ****************************************
  reg  [3:0]  state;
  reg  [31:0] settle_count;
  wire [4:0]  settle_shift = `SETTLE_BASE_SHIFT + {2'b00, o_osc_settle_select};
  wire        settle_done  = settle_count >= ((32'h1 << settle_shift) - 32'h1);

  always @(posedge i_clk)
  begin
    if (any_rst || int_rst)
    begin
      state <= ST_RUN;
      settle_count <= 32'h0;
    end
    else
    begin
      case (state)
        ST_RUN:
        begin
          settle_count <= 32'h0;
          if (i_stop_exec && wake)
            state <= ST_SETTLE;
          else if (i_stop_exec)
            state <= ST_STOP;
          else if (i_halt_exec && !wake)
            state <= ST_HALT;
        end
        ST_HALT:
          if (wake)
            state <= ST_RUN;
        ST_STOP:
          if (wake)
            state <= ST_SETTLE;
        ST_SETTLE:
        begin
          settle_count <= settle_count + 32'h1;
          if (settle_done)
            state <= ST_RUN;
        end
        default:
          state <= ST_RUN;
      endcase
    end
  end

  // ****************************************
  // settle select and clock monitor enable
  // ****************************************
  // writes land only in ST_RUN; writes in any other state are dropped
  always @(posedge i_clk)
  begin
    if (any_rst || int_rst)
      o_osc_settle_select <= `SETTLE_SEL_RESET;
    else if (i_settle_select_we && state == ST_RUN)
      o_osc_settle_select <= i_settle_select_data;
  end

  always @(posedge i_clk)
  begin
    if (any_rst || int_rst)
      o_clock_monitor_enable <= 1'b0;
    else if (i_clock_monitor_enable_set)
      o_clock_monitor_enable <= 1'b1;
  end

  // ****************************************
  // reset cause flags
  // ****************************************
  // firmware must read this as a whole byte
  always @(posedge i_clk)
  begin
    if (!i_rst_n)
      o_reset_cause_flags <= `CAUSE_RESET_VALUE;
    else if (int_rst)
    begin
      o_reset_cause_flags[`CAUSE_WDT_BIT] <= i_wdt_overflow;
      o_reset_cause_flags[`CAUSE_CLM_BIT] <= i_clock_monitor_trip;
      o_reset_cause_flags[`CAUSE_LVD_BIT] <= i_low_voltage_detect;
    end
    else if (ext_reset)
      o_reset_cause_flags <= `CAUSE_RESET_VALUE;
  end

  // ****************************************
  // outputs
  // ****************************************
  always @(posedge i_clk)
  begin
    if (any_rst || int_rst)
    begin
      o_main_crystal_clock_run <= !any_rst;
      o_internal_ring_clock_run <= !any_rst;
      o_system_reset_n <= 1'b0;
      o_wdt_reset_n <= 1'b0;
      o_low_voltage_detector_reset_n <= !any_rst;
      o_cpu_clock_enable <= 1'b0;
      o_halted <= 1'b0;
      o_stopped <= 1'b0;
      o_stop_retain_hold <= (state == ST_STOP) || o_stop_retain_hold;
      o_port_out <= {PORT_PINS{1'b0}};
      o_port_oe_n <= {PORT_PINS{1'b1}};
      o_port13_bit0_low_output <= 1'b0;
      o_port13_bit0_oe_n <= 1'b0;
    end
    else
    begin
      o_main_crystal_clock_run <= !(state == ST_STOP && i_cpu_on_main_crystal);
      o_internal_ring_clock_run <= 1'b1;
      o_system_reset_n <= 1'b1;
      o_wdt_reset_n <= 1'b1;
      o_low_voltage_detector_reset_n <= 1'b1;
      o_cpu_clock_enable <= state == ST_RUN;
      o_halted <= state == ST_HALT || state == ST_SETTLE;
      o_stopped <= state == ST_STOP;
      o_stop_retain_hold <= 1'b0;
      o_port_out <= i_port_out;
      o_port_oe_n <= ~i_port_drive;
      o_port13_bit0_low_output <= 1'b0;
      o_port13_bit0_oe_n <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// file: rtl/reset_standby_map.vh
// constants for the reset and standby controller
`ifndef RESET_STANDBY_MAP_VH
`define RESET_STANDBY_MAP_VH
// reset cause flag positions
`define CAUSE_WDT_BIT       0
`define CAUSE_CLM_BIT       1
`define CAUSE_LVD_BIT       2
`define CAUSE_WIDTH         8
`define CAUSE_RESET_VALUE   8'h00
// settle select width and reset value
`define SETTLE_SEL_WIDTH    3
`define SETTLE_SEL_RESET    3'h4
// least external reset low time
`define EXT_RESET_MIN_NS    10000
`define CLK_PERIOD_NS       5
`define EXT_RESET_CYCLES    ((`EXT_RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// settle wait base shift: wait = 2^(base + select) cycles
`define SETTLE_BASE_SHIFT   5'h0b
`endif
